// ---- logic/cmag_guard.sv ----
// CPU mode tracker and guard of the MMU and security registers.
// Function
// - System Mode reads and writes segmentation registers.
// - System Mode relocates table; table edits allowed.
// - User Mode blocked from all segmentation registers.
// - Segment table is ordinary memory, not guarded here.
// - Reset clears table base, disabling all segments.
// - Restrictive reset defaults nobody can override.
// - Memory partition fixed, no register changes it.
// - Contactless mode isolated; exchange window written by System only.
// - Security register written only by permitted mode.
// - Vector calls switch the CPU mode.
// - Exception entry switches mode; return restores it for up to STACK_DEPTH nested entries.
// - Long, absolute, extended call to special address switches.
// - Permitted write of status mode bits switches mode.
// - Denied read returns zero; denied write ignored.
// - User hardware access follows current segment rights.
`timescale 1ns/10ps
module cmag_guard
    import cmag_pkg::*;
#(
    parameter int STACK_DEPTH = 4,
    parameter logic [15:0] SYS_VECTOR = 16'h0100,
    parameter logic [15:0] CFG_VECTOR = 16'h0200,
    parameter logic [15:0] SPECIAL_CALL = 16'h0300
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [CMAG_SFR_AW-1:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [CMAG_SFR_DW-1:0] sfr_wdata,
    input wire logic seg_hw_rd,
    input wire logic seg_hw_wr,
    input wire logic fw_hw_rd,
    input wire logic fw_hw_wr,
    input wire logic call_valid,
    input wire logic [1:0] call_kind,
    input wire logic [CMAG_CODE_AW-1:0] call_target,
    input wire logic exc_entry,
    input wire logic return_from_interrupt_instr,
    output logic [CMAG_SFR_DW-1:0] sfr_rdata,
    output logic sfr_denied,
    output logic [2:0] cpu_mode,
    output logic [15:0] seg_base,
    output logic [15:0] xwin_base,
    output logic [7:0] xwin_size,
    output logic [15:0] partition
);

    localparam int PTR_W = $clog2(STACK_DEPTH + 1);
    localparam logic [PTR_W-1:0] STACK_FULL = PTR_W'(STACK_DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

    // All state of the guard, including the saved-mode stack.
    typedef struct packed
    {
        cmag_mode_type mode;
        logic [STACK_DEPTH-1:0][2:0] stack;
        logic [PTR_W-1:0] depth;
        logic [15:0] seg_base;
        logic [15:0] xwin_base;
        logic [7:0] xwin_size;
        logic [7:0] psw_upper;
        logic [7:0] rdata;
        logic denied;
        logic [15:0] partition;
    } cmag_state_type;

    cmag_state_type st; // Registered state.
    cmag_state_type next_st; // Next state.
    cmag_gate_if gi (); // Link to the access gate.
    logic rd_ok; // Read allowed this cycle.
    logic wr_ok; // Write allowed this cycle.
    logic [1:0] psw_code; // Mode field of a status register write.
    logic psw_mode_wr; // Permitted write of the status register.
    logic special_form; // Call is long, absolute or extended.

    // The gate decides every access in the cycle it is made.
    assign gi.mode = st.mode;
    assign gi.addr = sfr_addr;
    assign gi.seg_hw_rd = seg_hw_rd;
    assign gi.seg_hw_wr = seg_hw_wr;
    assign gi.fw_hw_rd = fw_hw_rd;
    assign gi.fw_hw_wr = fw_hw_wr;
    assign rd_ok = gi.rd_ok;
    assign wr_ok = gi.wr_ok;

    cmag_sfr_gate u_gate (
        .gi(gi)
    );

    // Next-state logic: register writes, read data and mode switching.
    always_comb
    begin
        next_st = st;
        psw_code = sfr_wdata[CMAG_PSW_MODE_LSB +: 2];
        psw_mode_wr = sfr_wr && wr_ok && (sfr_addr == CMAG_PSW_UPPER);
        special_form = (call_kind == CMAG_CALL_LONG) ||
            (call_kind == CMAG_CALL_ABS) || (call_kind == CMAG_CALL_EXT);
        // The partition has no write path at all.
        next_st.partition = CMAG_PARTITION;
        next_st.denied = (sfr_rd && !rd_ok) || (sfr_wr && !wr_ok);
        // Reads return zero when denied, never the real contents.
        next_st.rdata = CMAG_READ_DENIED;
        if (sfr_rd && rd_ok)
        begin
            case (sfr_addr)
                CMAG_SEG_BASE_LO: next_st.rdata = st.seg_base[7:0];
                CMAG_SEG_BASE_HI: next_st.rdata = st.seg_base[15:8];
                CMAG_PSW_UPPER: next_st.rdata = {st.psw_upper[7:2],
                    cmag_mode_code(st.mode)};
                CMAG_XWIN_BASE_LO: next_st.rdata = st.xwin_base[7:0];
                CMAG_XWIN_BASE_HI: next_st.rdata = st.xwin_base[15:8];
                CMAG_XWIN_SIZE: next_st.rdata = st.xwin_size;
                default: next_st.rdata = CMAG_READ_DENIED;
            endcase
        end
        // Writes land only when the gate allows them.
        if (sfr_wr && wr_ok)
        begin
            case (sfr_addr)
                CMAG_SEG_BASE_LO: next_st.seg_base[7:0] = sfr_wdata;
                CMAG_SEG_BASE_HI: next_st.seg_base[15:8] = sfr_wdata;
                CMAG_PSW_UPPER: next_st.psw_upper = sfr_wdata;
                CMAG_XWIN_BASE_LO: next_st.xwin_base[7:0] = sfr_wdata;
                CMAG_XWIN_BASE_HI: next_st.xwin_base[15:8] = sfr_wdata;
                CMAG_XWIN_SIZE: next_st.xwin_size = sfr_wdata;
                default: next_st.rdata = next_st.rdata;
            endcase
        end
        // Mode switching; exceptions outrank returns, status writes and
        // calls. A full stack stops saving, so very deep nesting loses
        // the newest return mode rather than corrupting the stack.
        if (exc_entry)
        begin
            if (st.depth != STACK_FULL)
            begin
                next_st.stack[st.depth] = st.mode;
                next_st.depth = st.depth + PTR_ONE;
            end
            next_st.mode = cmag_mode_system;
        end
        else if (return_from_interrupt_instr && st.depth != '0)
        begin
            next_st.depth = st.depth - PTR_ONE;
            next_st.mode = cmag_mode_type'(st.stack[st.depth - PTR_ONE]);
        end
        else if (psw_mode_wr)
        begin
            case (psw_code)
                CMAG_PSW_MODE_SYS: next_st.mode = cmag_mode_system;
                CMAG_PSW_MODE_USR: next_st.mode = cmag_mode_user;
                CMAG_PSW_MODE_CLOS: next_st.mode = cmag_mode_clos;
                default: next_st.mode = st.mode;
            endcase
        end
        else if (call_valid &&
            (call_target == SYS_VECTOR || call_target == CFG_VECTOR))
            next_st.mode = cmag_mode_system;
        else if (call_valid && special_form && call_target == SPECIAL_CALL)
            next_st.mode = cmag_mode_user;
    end

    // State register; reset loads fixed restrictive values only.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.mode <= cmag_mode_system;
            st.seg_base <= CMAG_SEG_BASE_RESET;
            st.xwin_base <= CMAG_XWIN_BASE_RESET;
            st.xwin_size <= CMAG_XWIN_SIZE_RESET;
            st.psw_upper <= CMAG_PSW_RESET;
            st.rdata <= CMAG_READ_DENIED;
            st.partition <= CMAG_PARTITION;
        end
        else
            st <= next_st;
    end

    // Outputs come straight from the state register.
    assign sfr_rdata = st.rdata;
    assign sfr_denied = st.denied;
    assign cpu_mode = st.mode;
    // Only the table base is guarded; the table itself is plain memory
    // whose entries follow the segment rights of the writer.
    assign seg_base = st.seg_base;
    assign xwin_base = st.xwin_base;
    assign xwin_size = st.xwin_size;
    assign partition = st.partition;

    // Exception entry followed directly by its return.
    sequence seq_enter_leave;
        exc_entry && st.depth != STACK_FULL ##1
        return_from_interrupt_instr && !exc_entry;
    endsequence

    // A clean cycle: no exception, return or register write.
    sequence seq_quiet;
        !exc_entry && !return_from_interrupt_instr && !sfr_wr;
    endsequence

    AST_USER_SEG_BLOCKED: assert property (@(posedge clock) disable iff (!rst_b)
        st.mode == cmag_mode_user && sfr_wr &&
        cmag_group(sfr_addr) == cmag_grp_mmu |=> $stable(seg_base))
        else $error("User Mode changed the segment table base.");

    AST_SEG_RESET_ZERO: assert property (@(posedge clock)
        !rst_b |=> seg_base == CMAG_SEG_BASE_RESET &&
        cpu_mode == cmag_mode_system)
        else $error("Reset left a nonzero table base.");

    AST_DENIED_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
        sfr_rd && !rd_ok |=> sfr_rdata == CMAG_READ_DENIED && sfr_denied)
        else $error("Denied read returned data.");

    AST_SYS_SEG_WRITE: assert property (@(posedge clock) disable iff (!rst_b)
        st.mode == cmag_mode_system && sfr_wr &&
        sfr_addr == CMAG_SEG_BASE_LO |=> seg_base[7:0] == $past(sfr_wdata))
        else $error("System Mode table base write lost.");

    AST_EXC_TO_SYSTEM: assert property (@(posedge clock) disable iff (!rst_b)
        exc_entry |=> cpu_mode == cmag_mode_system)
        else $error("Exception entry did not enter System Mode.");

    AST_RETURN_FROM_INTERRUPT_INSTR_RESTORES: assert property (@(posedge clock) disable iff (!rst_b)
        seq_enter_leave |=> cpu_mode == $past(cpu_mode, 2))
        else $error("Return did not restore the previous mode.");

    AST_VECTOR_CALL: assert property (@(posedge clock) disable iff (!rst_b)
        seq_quiet and call_valid && call_target == SYS_VECTOR
        |=> cpu_mode == cmag_mode_system)
        else $error("Vector call did not switch mode.");

    AST_SPECIAL_CALL: assert property (@(posedge clock) disable iff (!rst_b)
        seq_quiet and call_valid && special_form &&
        call_target == SPECIAL_CALL && call_target != SYS_VECTOR &&
        call_target != CFG_VECTOR |=> cpu_mode == cmag_mode_user)
        else $error("Special call did not switch mode.");

    AST_PSW_MODE: assert property (@(posedge clock) disable iff (!rst_b)
        !exc_entry && !return_from_interrupt_instr && psw_mode_wr &&
        psw_code == CMAG_PSW_MODE_USR
        |=> cpu_mode == cmag_mode_user)
        else $error("Status mode write did not switch mode.");

    AST_PARTITION_FIXED: assert property (@(posedge clock) disable iff (!rst_b)
        partition == CMAG_PARTITION)
        else $error("Memory partition moved.");

    AST_XWIN_SYSTEM_ONLY: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b) && !$stable(xwin_base) |->
        $past(cpu_mode) == cmag_mode_system)
        else $error("Exchange window changed outside System Mode.");

endmodule

// ---- pkg/cmag_pkg.sv ----
// Shared constants, types and decoding for the CPU mode and MMU access guard.
package cmag_pkg;

    // Widths of the special function register bus and code addresses.
    localparam int CMAG_SFR_AW = 8;
    localparam int CMAG_SFR_DW = 8;
    localparam int CMAG_CODE_AW = 16;

    // CPU modes, one-hot so that a corrupted code is easy to spot.
    typedef enum logic [2:0]
    {
        cmag_mode_system = 3'b001,
        cmag_mode_user = 3'b010,
        cmag_mode_clos = 3'b100
    } cmag_mode_type;

    // Register groups of the special function register space.
    typedef enum logic [5:0]
    {
        cmag_grp_cpu = 6'b000001,
        cmag_grp_mmu = 6'b000010,
        cmag_grp_sysmgmt = 6'b000100,
        cmag_grp_xwin = 6'b001000,
        cmag_grp_clos = 6'b010000,
        cmag_grp_hw = 6'b100000
    } cmag_grp_type;

    // Special function register addresses held by this block.
    localparam logic [7:0] CMAG_SEG_BASE_LO = 8'hA0;
    localparam logic [7:0] CMAG_SEG_BASE_HI = 8'hA1;
    localparam logic [7:0] CMAG_PSW_UPPER = 8'hA2;
    localparam logic [7:0] CMAG_XWIN_BASE_LO = 8'hA3;
    localparam logic [7:0] CMAG_XWIN_BASE_HI = 8'hA4;
    localparam logic [7:0] CMAG_XWIN_SIZE = 8'hA5;

    // Group boundaries of the register space.
    localparam logic [7:0] CMAG_GRP_MMU_FIRST = 8'hA0;
    localparam logic [7:0] CMAG_GRP_MMU_LAST = 8'hA1;
    localparam logic [7:0] CMAG_GRP_XWIN_FIRST = 8'hA3;
    localparam logic [7:0] CMAG_GRP_XWIN_LAST = 8'hA5;
    localparam logic [7:0] CMAG_GRP_CLOS_FIRST = 8'hA6;
    localparam logic [7:0] CMAG_GRP_CLOS_LAST = 8'hAF;
    localparam logic [7:0] CMAG_GRP_HW_FIRST = 8'hB0;

    // Reset values; zero table base disables every memory segment.
    localparam logic [15:0] CMAG_SEG_BASE_RESET = 16'h0000;
    localparam logic [15:0] CMAG_XWIN_BASE_RESET = 16'h0000;
    localparam logic [7:0] CMAG_XWIN_SIZE_RESET = 8'h00;
    localparam logic [7:0] CMAG_PSW_RESET = 8'h00;
    localparam logic [7:0] CMAG_READ_DENIED = 8'h00;

    // Fixed memory partition boundary between application and
    // contactless areas; no register can move it.
    localparam logic [15:0] CMAG_PARTITION = 16'hF000;

    // Mode field of the upper program status register.
    localparam int CMAG_PSW_MODE_LSB = 0;
    localparam logic [1:0] CMAG_PSW_MODE_SYS = 2'h0;
    localparam logic [1:0] CMAG_PSW_MODE_USR = 2'h1;
    localparam logic [1:0] CMAG_PSW_MODE_CLOS = 2'h2;

    // Call instruction kinds reported by the core.
    localparam logic [1:0] CMAG_CALL_OTHER = 2'h0;
    localparam logic [1:0] CMAG_CALL_LONG = 2'h1;
    localparam logic [1:0] CMAG_CALL_ABS = 2'h2;
    localparam logic [1:0] CMAG_CALL_EXT = 2'h3;

    // Decodes an address into its register group.
    function automatic cmag_grp_type cmag_group(input logic [7:0] addr);
        if (addr >= CMAG_GRP_HW_FIRST)
            return cmag_grp_hw;
        else if (addr >= CMAG_GRP_CLOS_FIRST && addr <= CMAG_GRP_CLOS_LAST)
            return cmag_grp_clos;
        else if (addr >= CMAG_GRP_XWIN_FIRST && addr <= CMAG_GRP_XWIN_LAST)
            return cmag_grp_xwin;
        else if (addr == CMAG_PSW_UPPER)
            return cmag_grp_sysmgmt;
        else if (addr >= CMAG_GRP_MMU_FIRST && addr <= CMAG_GRP_MMU_LAST)
            return cmag_grp_mmu;
        else
            return cmag_grp_cpu;
    endfunction

    // Maps a mode to its status register field code.
    function automatic logic [1:0] cmag_mode_code(input cmag_mode_type m);
        case (m)
            cmag_mode_user: return CMAG_PSW_MODE_USR;
            cmag_mode_clos: return CMAG_PSW_MODE_CLOS;
            default: return CMAG_PSW_MODE_SYS;
        endcase
    endfunction

endpackage

// ---- pkg/cmag_gate_if.sv ----
// Interface between the guard and its register access gate.
`timescale 1ns/10ps
interface cmag_gate_if;
    import cmag_pkg::*;
    cmag_mode_type mode; // Current CPU mode.
    logic [CMAG_SFR_AW-1:0] addr; // Register being accessed.
    logic seg_hw_rd; // Segment of running code grants hw reads.
    logic seg_hw_wr; // Segment of running code grants hw writes.
    logic fw_hw_rd; // Contactless firewall grants hw reads.
    logic fw_hw_wr; // Contactless firewall grants hw writes.
    logic rd_ok; // Read is allowed.
    logic wr_ok; // Write is allowed.
    modport guard (output mode, addr, seg_hw_rd, seg_hw_wr, fw_hw_rd,
        fw_hw_wr, input rd_ok, wr_ok);
    modport gate (input mode, addr, seg_hw_rd, seg_hw_wr, fw_hw_rd,
        fw_hw_wr, output rd_ok, wr_ok);
endinterface

// ---- logic/cmag_sfr_gate.sv ----
// Register access gate: grants reads and writes from mode and group.
`timescale 1ns/10ps
module cmag_sfr_gate
    import cmag_pkg::*;
(
    cmag_gate_if.gate gi
);

    // The decision is purely combinational so it is taken in the same
    // cycle as the access and a denied write never reaches a register.
    always_comb
    begin
        gi.rd_ok = 1'b0;
        gi.wr_ok = 1'b0;
        case (cmag_group(gi.addr))
            // General CPU registers are open in every mode.
            cmag_grp_cpu:
            begin
                gi.rd_ok = 1'b1;
                gi.wr_ok = 1'b1;
            end
            // Segmentation setup belongs to System Mode alone.
            cmag_grp_mmu:
            begin
                gi.rd_ok = (gi.mode == cmag_mode_system);
                gi.wr_ok = (gi.mode == cmag_mode_system);
            end
            // Status register is readable everywhere, writable by System.
            cmag_grp_sysmgmt:
            begin
                gi.rd_ok = 1'b1;
                gi.wr_ok = (gi.mode == cmag_mode_system);
            end
            // Exchange window: System configures, contactless reads.
            cmag_grp_xwin:
            begin
                gi.rd_ok = (gi.mode != cmag_mode_user);
                gi.wr_ok = (gi.mode == cmag_mode_system);
            end
            // Contactless operating system registers stay private.
            cmag_grp_clos:
            begin
                gi.rd_ok = (gi.mode == cmag_mode_clos);
                gi.wr_ok = (gi.mode == cmag_mode_clos);
            end
            // Hardware component rights depend on the mode.
            cmag_grp_hw:
            begin
                case (gi.mode)
                    cmag_mode_system:
                    begin
                        gi.rd_ok = 1'b1;
                        gi.wr_ok = 1'b1;
                    end
                    cmag_mode_user:
                    begin
                        gi.rd_ok = gi.seg_hw_rd;
                        gi.wr_ok = gi.seg_hw_wr;
                    end
                    cmag_mode_clos:
                    begin
                        gi.rd_ok = gi.fw_hw_rd;
                        gi.wr_ok = gi.fw_hw_wr;
                    end
                    default:
                    begin
                        gi.rd_ok = 1'b0;
                        gi.wr_ok = 1'b0;
                    end
                endcase
            end
            default:
            begin
                gi.rd_ok = 1'b0;
                gi.wr_ok = 1'b0;
            end
        endcase
    end

endmodule

// ---- test/cmag_core_model.sv ----
// Behavioural CPU core that issues guarded accesses and mode events.
`timescale 1ns/10ps
module cmag_core_model
    import cmag_pkg::*;
(
    input wire logic clock,
    input wire logic [CMAG_SFR_DW-1:0] sfr_rdata,
    input wire logic sfr_denied,
    output logic [CMAG_SFR_AW-1:0] sfr_addr,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [CMAG_SFR_DW-1:0] sfr_wdata,
    output logic seg_hw_rd,
    output logic seg_hw_wr,
    output logic fw_hw_rd,
    output logic fw_hw_wr,
    output logic call_valid,
    output logic [1:0] call_kind,
    output logic [CMAG_CODE_AW-1:0] call_target,
    output logic exc_entry,
    output logic return_from_interrupt_instr
);
    // Every line starts quiet, so reset sees no stray request.
    initial
    begin
        {sfr_addr, sfr_rd, sfr_wr, sfr_wdata} = '0;
        {seg_hw_rd, seg_hw_wr, fw_hw_rd, fw_hw_wr} = 4'h0;
        {call_valid, call_kind, call_target, exc_entry} = '0;
        return_from_interrupt_instr = 1'b0;
    end

    // Moves to just after the next rising edge, where inputs change.
    task automatic step();
        @(posedge clock);
        #2;
    endtask

    // Sets the segment and firewall rights as levels.
    task automatic rights(input logic [3:0] h);
        {seg_hw_rd, seg_hw_wr, fw_hw_rd, fw_hw_wr} = h;
    endtask

    // One access held over the taking edge; answer caught after it.
    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic n);
        sfr_rd = ~wr;
        sfr_wr = wr;
        sfr_addr = a;
        sfr_wdata = d;
        step();
        q = sfr_rdata;
        n = sfr_denied;
    endtask

    // Mode event: 0 call, 1 exception entry, 2 return.
    task automatic ev(input logic [1:0] sel, input logic [1:0] k,
        input logic [15:0] t);
        call_valid = (sel == 2'h0);
        call_kind = k;
        call_target = t;
        exc_entry = (sel == 2'h1);
        return_from_interrupt_instr = (sel == 2'h2);
        step();
    endtask

    // Releases strobes; data lines show inverted values, not stale.
    task automatic idle();
        {sfr_rd, sfr_wr, call_valid, exc_entry} = 4'h0;
        return_from_interrupt_instr = 1'b0;
        sfr_addr = ~sfr_addr;
        sfr_wdata = ~sfr_wdata;
        call_target = ~call_target;
        step();
    endtask
endmodule

// ---- test/cmag_guard_tb.sv ----
// Self-checking bench of the CPU mode and MMU access guard.
`timescale 1ns/10ps
module cmag_guard_tb;
    import cmag_pkg::*;
    localparam logic [15:0] SYSV = 16'h0100;
    localparam logic [15:0] CFGV = 16'h0200;
    localparam logic [15:0] SPEC = 16'h0300;
    // Access case: mode code, kind, address, data, rights, answer.
    typedef struct packed {
        logic [1:0] mode;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wd;
        logic [3:0] hw;
        logic [7:0] rd;
        logic den;
    } cmag_row_type;
    cmag_row_type rows [23] = '{
        '{2'h0, 1'h1, 8'hA0, 8'h5A, 4'h0, 8'h00, 1'h0},
        '{2'h0, 1'h0, 8'hA0, 8'h00, 4'h0, 8'h5A, 1'h0},
        '{2'h0, 1'h1, 8'hA1, 8'hC3, 4'h0, 8'h00, 1'h0},
        '{2'h0, 1'h0, 8'hA1, 8'h00, 4'h0, 8'hC3, 1'h0},
        '{2'h0, 1'h1, 8'hA3, 8'h77, 4'h0, 8'h00, 1'h0},
        '{2'h1, 1'h1, 8'hA0, 8'h11, 4'hF, 8'h00, 1'h1},
        '{2'h1, 1'h0, 8'hA1, 8'h00, 4'hF, 8'h00, 1'h1},
        '{2'h1, 1'h0, 8'hA2, 8'h00, 4'h0, 8'h01, 1'h0},
        '{2'h1, 1'h1, 8'hA3, 8'h22, 4'hF, 8'h00, 1'h1},
        '{2'h1, 1'h0, 8'hB0, 8'h00, 4'h8, 8'h00, 1'h0},
        '{2'h1, 1'h0, 8'hB0, 8'h00, 4'h7, 8'h00, 1'h1},
        '{2'h1, 1'h1, 8'hB1, 8'hAA, 4'hB, 8'h00, 1'h1},
        '{2'h1, 1'h1, 8'hB1, 8'hAA, 4'h4, 8'h00, 1'h0},
        '{2'h1, 1'h0, 8'hA6, 8'h00, 4'hF, 8'h00, 1'h1},
        '{2'h1, 1'h0, 8'h10, 8'h00, 4'h0, 8'h00, 1'h0},
        '{2'h2, 1'h0, 8'hA3, 8'h00, 4'h0, 8'h77, 1'h0},
        '{2'h2, 1'h1, 8'hA4, 8'h33, 4'h0, 8'h00, 1'h1},
        '{2'h2, 1'h0, 8'hA0, 8'h00, 4'hF, 8'h00, 1'h1},
        '{2'h2, 1'h0, 8'hB0, 8'h00, 4'hD, 8'h00, 1'h1},
        '{2'h2, 1'h0, 8'hB0, 8'h00, 4'h2, 8'h00, 1'h0},
        '{2'h2, 1'h0, 8'hA6, 8'h00, 4'h0, 8'h00, 1'h0},
        '{2'h0, 1'h0, 8'hA3, 8'h00, 4'h0, 8'h77, 1'h0},
        '{2'h0, 1'h1, 8'hA5, 8'h3C, 4'h0, 8'h00, 1'h0}
    };
    logic clock, rst_b, sfr_rd, sfr_wr, sfr_denied;
    logic seg_hw_rd, seg_hw_wr, fw_hw_rd, fw_hw_wr;
    logic call_valid, exc_entry, return_from_interrupt_instr, got_n;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xwin_size, got_d;
    logic [1:0] call_kind;
    logic [2:0] cpu_mode;
    logic [15:0] call_target, seg_base, xwin_base, partition;
    int fail_count = 0;
    int samples_checked = 0;

    // The core model drives every request input of the guard.
    cmag_core_model core (.clock(clock), .sfr_rdata(sfr_rdata),
        .sfr_denied(sfr_denied), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .seg_hw_rd(seg_hw_rd),
        .seg_hw_wr(seg_hw_wr), .fw_hw_rd(fw_hw_rd), .fw_hw_wr(fw_hw_wr),
        .call_valid(call_valid), .call_kind(call_kind),
        .call_target(call_target), .exc_entry(exc_entry),
        .return_from_interrupt_instr(return_from_interrupt_instr));

    cmag_guard #(.STACK_DEPTH(4), .SYS_VECTOR(SYSV), .CFG_VECTOR(CFGV),
        .SPECIAL_CALL(SPEC)) dut (.clock(clock), .rst_b(rst_b),
        .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .seg_hw_rd(seg_hw_rd),
        .seg_hw_wr(seg_hw_wr), .fw_hw_rd(fw_hw_rd), .fw_hw_wr(fw_hw_wr),
        .call_valid(call_valid), .call_kind(call_kind),
        .call_target(call_target), .exc_entry(exc_entry),
        .return_from_interrupt_instr(return_from_interrupt_instr),
        .sfr_rdata(sfr_rdata), .sfr_denied(sfr_denied),
        .cpu_mode(cpu_mode), .seg_base(seg_base), .xwin_base(xwin_base),
        .xwin_size(xwin_size), .partition(partition));

    // Free-running 20 MHz clock.
    initial clock = 1'b0;
    always #25 clock = ~clock;

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compares with case equality, so an unknown never matches.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One mode event (3 means a status write) and the mode it gives.
    task automatic mstep(input logic [1:0] sel, input logic [1:0] k,
        input logic [15:0] t, input cmag_mode_type exp);
        if (sel == 2'h3)
            core.acc(1'h1, CMAG_PSW_UPPER, t[7:0], got_d, got_n);
        else
            core.ev(sel, k, t);
        core.idle();
        chk(16'(cpu_mode), 16'(exp));
    endtask

    // Exception entry always lands in system mode, then a status write for user or contactless mode.
    task automatic set_mode(input logic [1:0] code);
        cmag_mode_type m;
        m = code == 2'h1 ? cmag_mode_user :
            code == 2'h2 ? cmag_mode_clos : cmag_mode_system;
        mstep(2'h1, 2'h0, 16'h0000, cmag_mode_system);
        if (code != 2'h0)
            mstep(2'h3, 2'h0, {14'h0000, code}, m);
    endtask

    // A hang must not pass silently.
    initial
    begin
        #250000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        rst_b = 1'b0;
        repeat (3) @(posedge clock);
        #2;
        rst_b = 1'b1;
        foreach (rows[i])
        begin
            set_mode(rows[i].mode);
            core.rights(rows[i].hw);
            core.acc(rows[i].wr, rows[i].addr, rows[i].wd, got_d, got_n);
            core.idle();
            chk(16'(got_d), 16'(rows[i].rd));
            chk(16'(got_n), 16'(rows[i].den));
        end
        chk(seg_base, 16'hC35A);
        chk(xwin_base, 16'h0077);
        chk(16'(xwin_size), 16'h003C);
        chk(partition, CMAG_PARTITION);
        // Reset in mid-run must bring back the restrictive defaults.
        rst_b = 1'b0;
        core.step();
        rst_b = 1'b1;
        chk(seg_base, 16'h0000);
        chk(16'(xwin_size), 16'h0000);
        chk(xwin_base, 16'h0000);
        chk(16'(cpu_mode), 16'(cmag_mode_system));
        chk(partition, CMAG_PARTITION);
        mstep(2'h2, 2'h0, 16'h0000, cmag_mode_system);
        mstep(2'h3, 2'h0, 16'h0003, cmag_mode_system);
        mstep(2'h3, 2'h0, 16'h0001, cmag_mode_user);
        mstep(2'h3, 2'h0, 16'h0000, cmag_mode_user);
        mstep(2'h0, 2'h0, CFGV, cmag_mode_system);
        mstep(2'h3, 2'h0, 16'h0002, cmag_mode_clos);
        mstep(2'h1, 2'h0, 16'h0000, cmag_mode_system);
        mstep(2'h3, 2'h0, 16'h0001, cmag_mode_user);
        mstep(2'h0, 2'h1, SYSV, cmag_mode_system);
        mstep(2'h2, 2'h0, 16'h0000, cmag_mode_clos);
        mstep(2'h1, 2'h0, 16'h0000, cmag_mode_system);
        // Each special call kind leaves system mode; a vector returns.
        for (int k = 1; k < 4; k++)
        begin
            mstep(2'h0, 2'(k), SPEC, cmag_mode_user);
            mstep(2'h0, 2'(k), SYSV, cmag_mode_system);
        end
        mstep(2'h0, 2'h0, SPEC, cmag_mode_system);
        mstep(2'h0, 2'h1, 16'h0301, cmag_mode_system);
        mstep(2'h2, 2'h0, 16'h0000, cmag_mode_clos);
        // Back-to-back: the mode change must guard the very next access.
        set_mode(2'h0);
        core.acc(1'h1, CMAG_SEG_BASE_LO, 8'h11, got_d, got_n);
        core.acc(1'h1, CMAG_PSW_UPPER, 8'h01, got_d, got_n);
        core.acc(1'h1, CMAG_SEG_BASE_LO, 8'hEE, got_d, got_n);
        core.idle();
        chk(16'(got_n), 16'h0001);
        chk(seg_base, 16'h0011);
        // Exception entry and its return on back-to-back cycles.
        core.ev(2'h1, 2'h0, 16'h0000);
        core.ev(2'h2, 2'h0, 16'h0000);
        core.idle();
        chk(16'(cpu_mode), 16'(cmag_mode_user));
        stop_test();
    end
endmodule
